// ### sensor_window_timing_map.svh
// register offsets, field widths, reset values and timing figures
// assumes it is included by the package and by the register bank
`ifndef SENSOR_WINDOW_TIMING_MAP_SVH
`define SENSOR_WINDOW_TIMING_MAP_SVH

`define SWT_ADDR_W 8
`define SWT_DATA_W 16

`define SWT_OFS_HEIGHT 8'h03
`define SWT_OFS_WIDTH 8'h04
`define SWT_OFS_HBLANK 8'h05
`define SWT_OFS_VBLANK 8'h06
`define SWT_OFS_OCTL 8'h07
`define SWT_OFS_SHUT_HI 8'h08
`define SWT_OFS_SHUT_LO 8'h09
`define SWT_OFS_DELAY 8'h0c

`define SWT_HEIGHT_W 11
`define SWT_WIDTH_W 12
`define SWT_HBLANK_W 12
`define SWT_VBLANK_W 11
`define SWT_SHUT_HI_W 4
`define SWT_SHUT_LO_W 16
`define SWT_DELAY_W 13
`define SWT_COL_W 13
`define SWT_ROW_W 12
`define SWT_EXPO_W 33

`define SWT_OCTL_HOLD_BIT 0
`define SWT_OCTL_ENABLE_BIT 1

`define SWT_RST_HEIGHT 11'h797
`define SWT_RST_WIDTH 12'ha1f
`define SWT_RST_HBLANK 12'h000
`define SWT_RST_VBLANK 11'h019
`define SWT_RST_OCTL 16'h1f82
`define SWT_RST_SHUT_HI 4'h0
`define SWT_RST_SHUT_LO 16'h0797
`define SWT_RST_DELAY 13'h0000

`define SWT_VBLANK_MIN 11'h008
`define SWT_HBLANK_MIN 12'h0b0
`define SWT_EXPOSURE_C 16'h00b4

`endif

// ### sensor_window_timing_pkg.sv
// types for the window, blanking and exposure register bank
// assumes the constants header sits in the same folder
`include "sensor_window_timing_map.svh"

package sensor_window_timing_pkg;

  typedef struct packed {
    logic [`SWT_HEIGHT_W-1:0] height;
    logic [`SWT_WIDTH_W-1:0] width;
    logic [`SWT_HBLANK_W-1:0] hblank;
    logic [`SWT_VBLANK_W-1:0] vblank;
    logic [`SWT_SHUT_HI_W-1:0] shut_hi;
    logic [`SWT_SHUT_LO_W-1:0] shut_lo;
    logic [`SWT_DELAY_W-1:0] delay;
  } cfg_t;

  typedef struct packed {
    cfg_t shadow;
    cfg_t active;
    logic [`SWT_DATA_W-1:0] octl;
    logic pend;
    logic bad_pend;
    logic [`SWT_COL_W-1:0] col;
    logic [`SWT_ROW_W-1:0] row;
    logic [`SWT_DATA_W-1:0] rdata;
    logic rvalid;
    logic fval;
    logic lval;
    logic fstart;
    logic bad;
    logic ren;
    logic lowp;
    logic [`SWT_COL_W-1:0] rperiod;
    logic [`SWT_EXPO_W-1:0] expo;
  } state_t;

  localparam cfg_t CFG_RESET = '{
    height: `SWT_RST_HEIGHT,
    width: `SWT_RST_WIDTH,
    hblank: `SWT_RST_HBLANK,
    vblank: `SWT_RST_VBLANK,
    shut_hi: `SWT_RST_SHUT_HI,
    shut_lo: `SWT_RST_SHUT_LO,
    delay: `SWT_RST_DELAY
  };

endpackage

// ### sensor_window_timing_regs.sv
// sensor window size, blanking, exposure and readout enable registers
// assumes the two-wire serial front end hands over decoded register
// reads and writes on clk_i, and that clk_i is also the pixel clock
`timescale 1ns/10ps
`include "sensor_window_timing_map.svh"

module sensor_window_timing_regs
  import sensor_window_timing_pkg::*;
#(
  parameter logic [`SWT_HBLANK_W-1:0] HBLANK_MIN = `SWT_HBLANK_MIN,
  parameter logic [`SWT_VBLANK_W-1:0] VBLANK_MIN = `SWT_VBLANK_MIN,
  parameter logic [15:0] EXPOSURE_C = `SWT_EXPOSURE_C
) (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [`SWT_ADDR_W-1:0] reg_addr_i,
  input wire logic [`SWT_DATA_W-1:0] reg_wdata_i,
  output logic [`SWT_DATA_W-1:0] reg_rdata_o,
  output logic reg_rvalid_o,
  output logic frame_valid_o,
  output logic line_valid_o,
  output logic frame_start_o,
  output logic bad_frame_o,
  output logic readout_en_o,
  output logic low_power_o,
  output logic update_pending_o,
  output logic [`SWT_COL_W-1:0] row_period_o,
  output logic [`SWT_EXPO_W-1:0] exposure_pclk_o
);

  // promote an even height to the next odd value
  function automatic logic [`SWT_HEIGHT_W-1:0] odd_height(
    input logic [`SWT_HEIGHT_W-1:0] v
  );
    odd_height = v | `SWT_HEIGHT_W'(1);
  endfunction

  // promote an even width to the next odd value
  function automatic logic [`SWT_WIDTH_W-1:0] odd_width(
    input logic [`SWT_WIDTH_W-1:0] v
  );
    odd_width = v | `SWT_WIDTH_W'(1);
  endfunction

  // raise a blanking value up to its floor
  function automatic logic [`SWT_HBLANK_W-1:0] floor_at(
    input logic [`SWT_HBLANK_W-1:0] v,
    input logic [`SWT_HBLANK_W-1:0] lo
  );
    floor_at = (v < lo) ? lo : v;
  endfunction

  // registers whose writes wait for a frame boundary
  function automatic logic is_frame_synced(
    input logic [`SWT_ADDR_W-1:0] a
  );
    case (a)
      `SWT_OFS_HEIGHT,
      `SWT_OFS_WIDTH,
      `SWT_OFS_HBLANK,
      `SWT_OFS_VBLANK,
      `SWT_OFS_SHUT_HI,
      `SWT_OFS_SHUT_LO,
      `SWT_OFS_DELAY: begin
        is_frame_synced = 1'b1;
      end
      default: begin
        is_frame_synced = 1'b0;
      end
    endcase
  endfunction

  // registers whose update spoils the frame that first uses it
  function automatic logic is_frame_spoiler(
    input logic [`SWT_ADDR_W-1:0] a
  );
    case (a)
      `SWT_OFS_HEIGHT,
      `SWT_OFS_WIDTH,
      `SWT_OFS_HBLANK: begin
        is_frame_spoiler = 1'b1;
      end
      default: begin
        is_frame_spoiler = 1'b0;
      end
    endcase
  endfunction

  // store a written word into the waiting configuration
  function automatic cfg_t write_cfg(
    input cfg_t c,
    input logic [`SWT_ADDR_W-1:0] a,
    input logic [`SWT_DATA_W-1:0] d
  );
    write_cfg = c;
    case (a)
      `SWT_OFS_HEIGHT: begin
        write_cfg.height = d[`SWT_HEIGHT_W-1:0];
      end
      `SWT_OFS_WIDTH: begin
        write_cfg.width = d[`SWT_WIDTH_W-1:0];
      end
      `SWT_OFS_HBLANK: begin
        write_cfg.hblank = d[`SWT_HBLANK_W-1:0];
      end
      `SWT_OFS_VBLANK: begin
        write_cfg.vblank = d[`SWT_VBLANK_W-1:0];
      end
      `SWT_OFS_SHUT_HI: begin
        write_cfg.shut_hi = d[`SWT_SHUT_HI_W-1:0];
      end
      `SWT_OFS_SHUT_LO: begin
        write_cfg.shut_lo = d[`SWT_SHUT_LO_W-1:0];
      end
      `SWT_OFS_DELAY: begin
        write_cfg.delay = d[`SWT_DELAY_W-1:0];
      end
      default: begin
      end
    endcase
  endfunction

  // read mux over the written values
  function automatic logic [`SWT_DATA_W-1:0] read_word(
    input cfg_t c,
    input logic [`SWT_DATA_W-1:0] octl,
    input logic [`SWT_ADDR_W-1:0] a
  );
    case (a)
      `SWT_OFS_HEIGHT: begin
        read_word = `SWT_DATA_W'(c.height);
      end
      `SWT_OFS_WIDTH: begin
        read_word = `SWT_DATA_W'(c.width);
      end
      `SWT_OFS_HBLANK: begin
        read_word = `SWT_DATA_W'(c.hblank);
      end
      `SWT_OFS_VBLANK: begin
        read_word = `SWT_DATA_W'(c.vblank);
      end
      `SWT_OFS_OCTL: begin
        read_word = octl;
      end
      `SWT_OFS_SHUT_HI: begin
        read_word = `SWT_DATA_W'(c.shut_hi);
      end
      `SWT_OFS_SHUT_LO: begin
        read_word = c.shut_lo;
      end
      `SWT_OFS_DELAY: begin
        read_word = `SWT_DATA_W'(c.delay);
      end
      default: begin
        read_word = '0;
      end
    endcase
  endfunction

  state_t st_ff;
  state_t nxt_st;

  logic [`SWT_ROW_W-1:0] act_rows;
  logic [`SWT_COL_W-1:0] act_cols;
  logic [`SWT_HBLANK_W-1:0] hbl_eff;
  logic [`SWT_VBLANK_W-1:0] vbl_eff;
  logic [`SWT_COL_W-1:0] row_len;
  logic [`SWT_ROW_W-1:0] frame_rows;
  logic [`SWT_SHUT_LO_W-1:0] lo_eff;
  logic [19:0] shutter;
  logic [`SWT_EXPO_W-1:0] product;
  logic [`SWT_EXPO_W:0] expo_diff;
  logic hold;
  logic enable;
  logic boundary;
  logic row_end;
  logic frame_end;
  logic apply_now;
  logic wr_sync;
  logic wr_spoil;

  // derived timing from the applied configuration
  always_comb begin
    // odd promotion of size fields
    act_rows = `SWT_ROW_W'(odd_height(st_ff.active.height)) + `SWT_ROW_W'(1);
    act_cols = `SWT_COL_W'(odd_width(st_ff.active.width)) + `SWT_COL_W'(1);
    hbl_eff = floor_at(st_ff.active.hblank, HBLANK_MIN);
    vbl_eff = `SWT_VBLANK_W'(floor_at(`SWT_HBLANK_W'(st_ff.active.vblank),
                                      `SWT_HBLANK_W'(VBLANK_MIN)));
    row_len = act_cols + `SWT_COL_W'(hbl_eff);
    frame_rows = act_rows + `SWT_ROW_W'(vbl_eff) + `SWT_ROW_W'(1);
    // zero lower shutter acts as one
    lo_eff = (st_ff.active.shut_lo == '0) ? `SWT_SHUT_LO_W'(1) : st_ff.active.shut_lo;
    shutter = {st_ff.active.shut_hi, lo_eff};
    product = `SWT_EXPO_W'(shutter) * `SWT_EXPO_W'(row_len);
    expo_diff = {1'b0, product} - (`SWT_EXPO_W+1)'(st_ff.active.delay)
                - (`SWT_EXPO_W+1)'(EXPOSURE_C);
  end

  always_comb begin
    hold = st_ff.octl[`SWT_OCTL_HOLD_BIT];
    enable = st_ff.octl[`SWT_OCTL_ENABLE_BIT];
    row_end = (st_ff.col == row_len - `SWT_COL_W'(1));
    frame_end = row_end && (st_ff.row == frame_rows - `SWT_ROW_W'(1));
    boundary = frame_end || !enable;
    apply_now = boundary && st_ff.pend && !hold;
    wr_sync = reg_wr_i && is_frame_synced(reg_addr_i);
    wr_spoil = reg_wr_i && is_frame_spoiler(reg_addr_i);
  end

  always_comb begin
    nxt_st = st_ff;
    nxt_st.fstart = 1'b0;
    nxt_st.rvalid = 1'b0;

    if (!enable) begin
      nxt_st.col = '0;
      nxt_st.row = '0;
    end else if (row_end) begin
      nxt_st.col = '0;
      if (frame_end) begin
        nxt_st.row = '0;
        nxt_st.fstart = 1'b1;
      end else begin
        nxt_st.row = st_ff.row + `SWT_ROW_W'(1);
      end
    end else begin
      nxt_st.col = st_ff.col + `SWT_COL_W'(1);
    end

    // released writes still wait for boundary
    if (apply_now) begin
      nxt_st.active = st_ff.shadow;
      nxt_st.pend = 1'b0;
      nxt_st.bad_pend = 1'b0;
    end
    if (frame_end) begin
      nxt_st.bad = apply_now && st_ff.bad_pend;
    end

    // register writes; a write at a boundary re-arms pending
    if (reg_wr_i) begin
      nxt_st.shadow = write_cfg(st_ff.shadow, reg_addr_i, reg_wdata_i);
    end
    if (reg_wr_i && reg_addr_i == `SWT_OFS_OCTL) begin
      nxt_st.octl = reg_wdata_i;
    end
    if (wr_sync) begin
      nxt_st.pend = 1'b1;
    end
    // size and row blanking spoil a frame
    if (wr_spoil) begin
      nxt_st.bad_pend = 1'b1;
    end

    // register reads return the written values
    if (reg_rd_i) begin
      nxt_st.rvalid = 1'b1;
      nxt_st.rdata = read_word(st_ff.shadow, st_ff.octl, reg_addr_i);
    end

    // timing flags for the current pixel
    nxt_st.fval = enable && (st_ff.row < act_rows);
    nxt_st.lval = enable && (st_ff.row < act_rows) && (st_ff.col < act_cols);
    nxt_st.ren = enable;
    nxt_st.lowp = !enable;
    nxt_st.rperiod = row_len;
    // clamp a negative result at zero
    nxt_st.expo = expo_diff[`SWT_EXPO_W] ? '0 : expo_diff[`SWT_EXPO_W-1:0];
  end

  // one register holds all state
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      st_ff <= '{
        shadow: CFG_RESET,
        active: CFG_RESET,
        octl: `SWT_RST_OCTL,
        default: '0
      };
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign reg_rdata_o = st_ff.rdata;
  assign reg_rvalid_o = st_ff.rvalid;
  assign frame_valid_o = st_ff.fval;
  assign line_valid_o = st_ff.lval;
  assign frame_start_o = st_ff.fstart;
  assign bad_frame_o = st_ff.bad;
  assign readout_en_o = st_ff.ren;
  assign low_power_o = st_ff.lowp;
  assign update_pending_o = st_ff.pend;
  assign row_period_o = st_ff.rperiod;
  assign exposure_pclk_o = st_ff.expo;

endmodule

// ### sensor_window_timing_regs_tb.sv
// self-checking bench for the window timing register bank
// assumes the host model and checker are compiled before it
`timescale 1ns/10ps
module sensor_window_timing_regs_tb;
  logic clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic wr, rd, rvalid, fval, lval, fstart, bad, ren, lowp, pend, fbad;
  logic [7:0] addr;
  logic [15:0] wdata, rdata, q;
  logic [12:0] rperiod;
  logic [32:0] expo;
  int error_cnt = 0;
  int check_count = 0;
  int flen, nline;
  initial forever #50 clk_i = ~clk_i;
  swt_host u_host (.clk_i(clk_i), .rdata_i(rdata), .rvalid_i(rvalid), .wr_o(wr), .rd_o(rd),
    .addr_o(addr), .wdata_o(wdata));
  sensor_window_timing_regs #(.HBLANK_MIN(12'h008)) u_dut (.clk_i(clk_i),
    .sys_rst_i(sys_rst_i), .reg_wr_i(wr), .reg_rd_i(rd), .reg_addr_i(addr),
    .reg_wdata_i(wdata), .reg_rdata_o(rdata), .reg_rvalid_o(rvalid), .frame_valid_o(fval),
    .line_valid_o(lval), .frame_start_o(fstart), .bad_frame_o(bad), .readout_en_o(ren),
    .low_power_o(lowp), .update_pending_o(pend), .row_period_o(rperiod),
    .exposure_pclk_o(expo));
  task automatic chk(input string nm, input logic [32:0] s, input logic [32:0] e);
    check_count++;
    if (s !== e) begin
      error_cnt++;
      $display("ERROR %s expected %0h seen %0h", nm, e, s);
    end
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // measures one frame from the next start pulse
  task automatic frame;
    int n;
    n = 0;
    while (fstart !== 1'b1 && n < 3000) begin
      @(negedge clk_i);
      n++;
    end
    fbad = bad;
    flen = 0;
    nline = 0;
    do begin
      @(negedge clk_i);
      flen++;
      nline += lval;
    end while (fstart !== 1'b1 && flen < 3000);
  endtask
  task automatic t_reset;
    logic [15:0] rv [7] = '{16'h0797, 16'h0a1f, 16'h0000, 16'h0019, 16'h1f82, 16'h0000,
      16'h0797};
    for (int i = 0; i < 7; i++) begin
      u_host.rd(8'(i + 3), q);
      chk("read valid", rvalid, 1'b1);
      chk("reset value", q, rv[i]);
    end
    u_host.rd(8'h0a, q);
    chk("unmapped read", q, 0);
    chk("enable", {ren, lowp}, 2'b10);
    chk("row period", rperiod, 13'd2600);
    $display("reset test done");
  endtask
  task automatic t_shrink;
    u_host.wr(8'h07, 16'h0000);
    u_host.wr(8'h03, 16'h0002);
    u_host.wr(8'h04, 16'h0004);
    u_host.wr(8'h06, 16'h0003);
    u_host.wr(8'h08, 16'h0001);
    u_host.wr(8'h09, 16'h0000);
    u_host.wr(8'h0c, 16'h0005);
    repeat (3) @(negedge clk_i);
    chk("low power", {ren, lowp, fval}, 3'b010);
    u_host.rd(8'h04, q);
    chk("width readback", q, 16'h0004);
    u_host.rd(8'h0c, q);
    chk("delay readback", q, 16'h0005);
    chk("row period", rperiod, 13'd14);
    chk("exposure", expo, 33'd917333);
    u_host.wr(8'h07, 16'h0002);
    frame();
    frame();
    chk("frame length", flen, 182);
    chk("active pixels", nline, 24);
    $display("window test done");
  endtask
  task automatic t_hblank;
    u_host.wr(8'h04, 16'h0005);
    u_host.wr(8'h05, 16'h0014);
    chk("pending", pend, 1'b1);
    frame();
    chk("bad frame", fbad, 1'b1);
    chk("row period", rperiod, 13'd26);
    chk("frame length", flen, 338);
    chk("exposure up", expo, 33'd1703777);
    frame();
    chk("bad frame clear", {fbad, pend}, 2'b00);
    $display("row blanking test done");
  endtask
  task automatic t_hold;
    u_host.wr(8'h07, 16'h0003);
    u_host.wr(8'h06, 16'h000a);
    frame();
    frame();
    chk("held", {pend, 32'(flen)}, {1'b1, 32'd338});
    u_host.wr(8'h07, 16'h0002);
    chk("still pending", pend, 1'b1);
    frame();
    chk("released length", flen, 390);
    chk("no bad frame", fbad, 1'b0);
    chk("exposure kept", expo, 33'd1703777);
    $display("hold test done");
  endtask
  initial begin
    repeat (30000) @(posedge clk_i);
    error_cnt++;
    summarize();
  end
  initial begin
    repeat (6) @(negedge clk_i);
    sys_rst_i = 1'b0;
    t_reset();
    t_shrink();
    t_hblank();
    t_hold();
    summarize();
  end
endmodule

// ### swt_host.sv
// host model on the decoded register port
// assumes requests change at the falling clock edge
`timescale 1ns/10ps
module swt_host (
  input wire logic clk_i,
  input wire logic [15:0] rdata_i,
  input wire logic rvalid_i,
  output logic wr_o,
  output logic rd_o,
  output logic [7:0] addr_o,
  output logic [15:0] wdata_o
);
  initial begin
    wr_o = 1'b0;
    rd_o = 1'b0;
    addr_o = 8'h00;
    wdata_o = 16'h0000;
  end
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(negedge clk_i);
    addr_o = a;
    wdata_o = d;
    wr_o = 1'b1;
    @(negedge clk_i);
    wr_o = 1'b0;
    addr_o = ~a;
    wdata_o = ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    int n;
    @(negedge clk_i);
    addr_o = a;
    rd_o = 1'b1;
    @(negedge clk_i);
    rd_o = 1'b0;
    addr_o = ~a;
    n = 0;
    while (rvalid_i !== 1'b1 && n < 4) begin
      @(negedge clk_i);
      n++;
    end
    d = rdata_i;
  endtask
endmodule

// ### swt_monitor.sv
// port checker for the window timing register bank
// assumes the constants header is on the include path
`timescale 1ns/10ps
`include "sensor_window_timing_map.svh"
module swt_monitor (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [`SWT_ADDR_W-1:0] reg_addr_i,
  input wire logic [`SWT_DATA_W-1:0] reg_wdata_i,
  input wire logic [`SWT_DATA_W-1:0] reg_rdata_o,
  input wire logic reg_rvalid_o,
  input wire logic frame_valid_o,
  input wire logic line_valid_o,
  input wire logic frame_start_o,
  input wire logic bad_frame_o,
  input wire logic readout_en_o,
  input wire logic low_power_o,
  input wire logic update_pending_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  a_read_answer: assert property (reg_rvalid_o == $past(reg_rd_i))
    else $error("read answer timing wrong");
  a_rdata_holds: assert property (!reg_rvalid_o |-> $stable(reg_rdata_o))
    else $error("read data moved without a read");
  a_enable_follows: assert property (reg_wr_i && reg_addr_i == 8'h07
    |-> ##2 readout_en_o == $past(reg_wdata_i[1], 2)) else $error("readout enable not taken");
  a_power_inverse: assert property (!$past(sys_rst_i) |-> low_power_o != readout_en_o)
    else $error("low power not inverse of enable");
  a_disabled_idle: assert property (!readout_en_o [*2]
    |-> !frame_valid_o && !line_valid_o && !frame_start_o) else $error("readout while off");
  a_write_pends: assert property (readout_en_o && reg_wr_i
    && reg_addr_i inside {[8'h03:8'h06], 8'h08, 8'h09} |=> update_pending_o)
    else $error("deferred write not pending");
  a_start_single: assert property (frame_start_o |=> !frame_start_o)
    else $error("frame start longer than one cycle");
  a_line_in_frame: assert property (line_valid_o |-> frame_valid_o)
    else $error("line valid outside frame");
  c_frame: cover property (frame_start_o);
  c_apply: cover property ($fell(update_pending_o));
  c_bad: cover property ($rose(bad_frame_o));
endmodule
bind sensor_window_timing_regs swt_monitor u_mon (.*);
